// ### core/lin_phy_control.sv
`timescale 1ns/1ns
`include "lin_phy_cfg.svh"
// Functional notes
// - Overheat forces transmitter off, status follows
// - Overheat with enable raises interrupt request
// - New interrupt only after condition reoccurs
// - Transmitter resumes when cool and transmit request low
// - Low power: transmitter off, receiver watching
// - Long dominant then rising edge wakes
// - Keep-alive zero holds recessive on undervoltage
// - Undervoltage blocking reported by flag
// - Lines route to serial, gpio, direct
// - Ready set about 50 us after enable
// - Bus recessive until ready
// - Decode offsets from both base addresses
// - Interrupt enable written only with mask
// - Direct drive written only with mask
// - Keep-alive written only with mask
// - Module enable written only with mask
// - Slew written only when mask is 11
// - Slew codes: normal, slow, fast, normal
// - Direct drive one forces dominant
// - Control reads zero, resets zero
// - Fault flags latch, clear by write one
// - Serial source wins over gpio
// - Routed source ORed with direct drive
// - Receive bit one when bus dominant
module lin_phy_control #(
  parameter int READY_CYCLES = `READY_CYCLES,
  parameter int WAKE_CYCLES = `WAKE_DOM_CYCLES
) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_B_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic OVERHEAT_IN,
  input wire logic DISTURBANCE_IN,
  input wire logic LOW_SUPPLY_IN,
  input wire logic LOW_POWER_IN,
  input wire logic BUS_RX_IN,
  input wire logic SERIAL_TX_IN,
  input wire logic GPIO_TX_IN,
  output logic BUS_TX_DOMINANT_OUT,
  output logic SERIAL_RX_OUT,
  output logic GPIO_RX_OUT,
  output lin_phy_pkg::slew_t SLEW_OUT,
  output logic OVERHEAT_IRQ_OUT,
  output logic WAKE_EVENT_OUT
);
  import lin_phy_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0] oh_s;
    logic [1:0] dist_s;
    logic [1:0] uv_s;
    logic [1:0] rx_s;
    logic overheat_irq_enable;
    logic direct_drive;
    logic low_supply_keep_alive;
    logic module_on;
    slew_t slew_select;
    logic overheat_flag;
    logic disturbance_flag;
    logic undervoltage_flag;
    logic tx_from_gpio;
    logic tx_from_serial;
    logic rx_to_gpio;
    logic rx_to_serial;
    logic [1:0] wake_source_reg;
    logic oh_prev;
    logic tx_locked;
    txs_t txs;
    logic [15:0] rdy_cnt;
    logic [15:0] dom_cnt;
    logic dom_long;
    logic rx_prev;
    logic wake_pulse;
    logic tx_drive;
    logic [31:0] rdata;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic access;
  logic wr;
  logic [7:0] ofs;
  logic hit;
  logic oh;
  logic rx_dom;
  logic routed_tx;
  logic tx_request;
  logic uv_block;
  logic ready;

  // ==========================================================
  // Address decode
  always_comb begin
    access = PSEL_IN && PENABLE_IN;
    wr = access && PWRITE_IN;
    ofs = 8'h00;
    hit = 1'b0;
    if (PADDR_IN[1:0] == 2'b00) begin
      // Word index sits in bits 11:2, its top two bits pick the base
      if (PADDR_IN[11:10] == 2'(`BASE_NONBLOCKING >> 8)) begin
        ofs = PADDR_IN[9:2];
        hit = 1'b1;
      end else if (PADDR_IN[11:10] == 2'(`BASE_BLOCKING >> 8)) begin
        ofs = PADDR_IN[9:2];
        hit = 1'b1;
      end
    end
    if (hit) begin
      hit = ofs inside {`OFS_CTL, `OFS_FAULT, `OFS_LINE, `OFS_TXR, `OFS_RXR, `OFS_SPA, `OFS_SPB, `OFS_WAKE, `OFS_MODE};
    end
  end

  // ==========================================================
  // Block logic
  always_comb begin
    st_next = st_reg;
    oh = st_reg.oh_s[1];
    rx_dom = st_reg.rx_s[1];
    st_next.oh_s = {st_reg.oh_s[0], OVERHEAT_IN};
    st_next.dist_s = {st_reg.dist_s[0], DISTURBANCE_IN};
    st_next.uv_s = {st_reg.uv_s[0], LOW_SUPPLY_IN};
    st_next.rx_s = {st_reg.rx_s[0], BUS_RX_IN};
    st_next.oh_prev = oh;
    st_next.rx_prev = rx_dom;
    st_next.wake_pulse = 1'b0;
    routed_tx = st_reg.tx_from_serial ? SERIAL_TX_IN : (st_reg.tx_from_gpio && GPIO_TX_IN);
    tx_request = routed_tx || st_reg.direct_drive;
    uv_block = st_reg.uv_s[1] && !st_reg.low_supply_keep_alive;
    ready = st_reg.txs == TXS_READY;
    // Overheat lock released only when cool and data recessive
    if (oh) begin
      st_next.tx_locked = 1'b1;
    end else if (!tx_request) begin
      st_next.tx_locked = 1'b0;
    end
    // Ready delay after enable
    unique case (st_reg.txs)
      TXS_OFF: begin
        st_next.rdy_cnt = 16'h0000;
        if (st_reg.module_on) begin
          st_next.txs = TXS_INIT;
        end
      end
      TXS_INIT: begin
        if (!st_reg.module_on) begin
          st_next.txs = TXS_OFF;
        end else if (st_reg.rdy_cnt == 16'(READY_CYCLES - 1)) begin
          st_next.txs = TXS_READY;
        end else begin
          st_next.rdy_cnt = st_reg.rdy_cnt + 16'h0001;
        end
      end
      TXS_READY: begin
        if (!st_reg.module_on) begin
          st_next.txs = TXS_OFF;
        end
      end
      default: st_next.txs = TXS_OFF;
    endcase
    // Wake detection on long dominant then rising edge
    if (rx_dom) begin
      if (st_reg.dom_cnt != 16'hFFFF) begin
        st_next.dom_cnt = st_reg.dom_cnt + 16'h0001;
      end
      if (st_reg.dom_cnt >= 16'(WAKE_CYCLES)) begin
        st_next.dom_long = 1'b1;
      end
    end else begin
      st_next.dom_cnt = 16'h0000;
      st_next.dom_long = 1'b0;
      if (st_reg.rx_prev && st_reg.dom_long && LOW_POWER_IN) begin
        st_next.wake_pulse = 1'b1;
      end
    end
    // Final drive: recessive unless ready, cool, powered, supplied
    st_next.tx_drive = tx_request && ready && !st_reg.tx_locked && !oh && !LOW_POWER_IN && !uv_block;
    // Register writes
    if (wr && hit) begin
      unique case (ofs)
        `OFS_CTL: begin
          if (PSTRB_IN[1:0] == 2'b11) begin
            if (PWDATA_IN[`CTL_IEM_BIT]) st_next.overheat_irq_enable = PWDATA_IN[`CTL_IE_BIT];
            if (PWDATA_IN[`CTL_DDM_BIT]) st_next.direct_drive = PWDATA_IN[`CTL_DD_BIT];
            if (PWDATA_IN[`CTL_KAM_BIT]) st_next.low_supply_keep_alive = PWDATA_IN[`CTL_KA_BIT];
            if (PWDATA_IN[`CTL_ENM_BIT]) st_next.module_on = PWDATA_IN[`CTL_EN_BIT];
            if (PWDATA_IN[9:8] == 2'b11) st_next.slew_select = slew_t'(PWDATA_IN[1:0]);
          end
        end
        `OFS_FAULT: begin
          if (PWDATA_IN[`FLT_OT_BIT]) st_next.overheat_flag = 1'b0;
          if (PWDATA_IN[`FLT_HF_BIT]) st_next.disturbance_flag = 1'b0;
          if (PWDATA_IN[`FLT_UV_BIT]) st_next.undervoltage_flag = 1'b0;
        end
        `OFS_TXR: begin
          st_next.tx_from_gpio = PWDATA_IN[1];
          st_next.tx_from_serial = PWDATA_IN[0];
        end
        `OFS_RXR: begin
          st_next.rx_to_gpio = PWDATA_IN[1];
          st_next.rx_to_serial = PWDATA_IN[0];
        end
        `OFS_WAKE: begin
          st_next.wake_source_reg = st_reg.wake_source_reg & ~PWDATA_IN[1:0];
        end
        default: begin
        end
      endcase
    end
    // Sticky flags, set wins over clear
    if (oh && !st_reg.oh_prev) st_next.overheat_flag = 1'b1;
    if (st_reg.dist_s[1]) st_next.disturbance_flag = 1'b1;
    if (uv_block && tx_request) st_next.undervoltage_flag = 1'b1;
    if (st_next.wake_pulse) st_next.wake_source_reg[0] = 1'b1;
    // Read data
    // Captured in the setup phase so it stands through the access phase
    if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
      st_next.rdata = 32'h0000_0000;
    end
    if (PSEL_IN && !PENABLE_IN && !PWRITE_IN && hit) begin
      unique case (ofs)
        `OFS_FAULT: st_next.rdata[7:0] = {st_reg.overheat_flag, 1'b0, st_reg.disturbance_flag, 1'b0,
                                          st_reg.undervoltage_flag, 3'b000};
        `OFS_LINE: st_next.rdata[7:0] = {ready, 5'b00000, rx_dom, st_reg.tx_drive};
        `OFS_TXR: st_next.rdata[1:0] = {st_reg.tx_from_gpio, st_reg.tx_from_serial};
        `OFS_RXR: st_next.rdata[1:0] = {st_reg.rx_to_gpio, st_reg.rx_to_serial};
        `OFS_WAKE: st_next.rdata[1:0] = st_reg.wake_source_reg;
        `OFS_MODE: st_next.rdata[2:0] = {oh, st_reg.slew_select};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
    if (!RST_B_IN) begin
      st_next = '0;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    st_reg <= st_next;
  end

  // ==========================================================
  // Outputs
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = access && !hit;
  assign PRDATA_OUT = st_reg.rdata;
  assign BUS_TX_DOMINANT_OUT = st_reg.tx_drive;
  assign SERIAL_RX_OUT = st_reg.rx_to_serial ? rx_dom : 1'b0;
  assign GPIO_RX_OUT = st_reg.rx_to_gpio ? rx_dom : 1'b0;
  assign SLEW_OUT = st_reg.slew_select;
  assign OVERHEAT_IRQ_OUT = st_reg.overheat_flag && st_reg.overheat_irq_enable;
  assign WAKE_EVENT_OUT = st_reg.wake_pulse;

  // ==========================================================
  // Checks
  a_tx_off_hot: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    st_reg.oh_s[1] |=> !BUS_TX_DOMINANT_OUT) else $error("tx driven while hot");
  a_irq_on_hot: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (st_reg.oh_s[1] && !st_reg.oh_prev && st_reg.overheat_irq_enable) |=> ##0 OVERHEAT_IRQ_OUT)
    else $error("no overheat irq");
  a_no_retrigger: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    ($fell(st_reg.overheat_flag) && st_reg.oh_prev && st_reg.oh_s[1]) |=> !st_reg.overheat_flag)
    else $error("overheat retriggered");
  a_lowpwr_off: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    LOW_POWER_IN |=> !BUS_TX_DOMINANT_OUT) else $error("tx in low power");
  a_ready_delay: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    $rose(st_reg.module_on) |-> !ready [*8]) else $error("ready too early");
  a_init_reces: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (st_reg.txs != TXS_READY) |=> !BUS_TX_DOMINANT_OUT) else $error("tx before ready");
  a_slew_mask: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (wr && hit && ofs == `OFS_CTL && PWDATA_IN[9:8] != 2'b11) |=> $stable(st_reg.slew_select))
    else $error("slew changed without mask");
  a_ie_mask: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (wr && hit && ofs == `OFS_CTL && !PWDATA_IN[`CTL_IEM_BIT]) |=> $stable(st_reg.overheat_irq_enable))
    else $error("irq enable changed without mask");
  a_ctl_reads0: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (access && !PWRITE_IN && hit && ofs == `OFS_CTL) |-> PRDATA_OUT == 32'h0000_0000)
    else $error("ctl read nonzero");
  a_dd_mask: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (wr && hit && ofs == `OFS_CTL && !PWDATA_IN[`CTL_DDM_BIT]) |=> $stable(st_reg.direct_drive))
    else $error("direct drive changed without mask");
  a_ka_mask: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (wr && hit && ofs == `OFS_CTL && !PWDATA_IN[`CTL_KAM_BIT]) |=> $stable(st_reg.low_supply_keep_alive))
    else $error("keep-alive changed without mask");
  a_en_mask: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (wr && hit && ofs == `OFS_CTL && !PWDATA_IN[`CTL_ENM_BIT]) |=> $stable(st_reg.module_on))
    else $error("enable changed without mask");

  // ==========================================================
  // Fault and drive checks
  a_ot_sticky: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (st_reg.overheat_flag && !(wr && hit && ofs == `OFS_FAULT && PWDATA_IN[`FLT_OT_BIT]))
    |=> st_reg.overheat_flag)
    else $error("overheat flag lost");
  a_hf_sticky: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (st_reg.disturbance_flag && !(wr && hit && ofs == `OFS_FAULT && PWDATA_IN[`FLT_HF_BIT]))
    |=> st_reg.disturbance_flag)
    else $error("disturbance flag lost");
  a_uv_sticky: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (st_reg.undervoltage_flag && !(wr && hit && ofs == `OFS_FAULT && PWDATA_IN[`FLT_UV_BIT]))
    |=> st_reg.undervoltage_flag)
    else $error("undervoltage flag lost");
  a_ot_edge: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    $rose(st_reg.overheat_flag) |-> (st_reg.oh_prev && !$past(st_reg.oh_prev)))
    else $error("overheat flag without new event");
  a_uv_recessive: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (st_reg.uv_s[1] && !st_reg.low_supply_keep_alive) |=> !BUS_TX_DOMINANT_OUT)
    else $error("tx driven in undervoltage");
  a_uv_flag_set: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (st_reg.uv_s[1] && !st_reg.low_supply_keep_alive && tx_request) |=> st_reg.undervoltage_flag)
    else $error("undervoltage block not flagged");
  a_serial_wins: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (st_reg.tx_from_serial && !SERIAL_TX_IN && !st_reg.direct_drive) |-> !tx_request)
    else $error("gpio source not ignored");
  a_drive_or: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (st_reg.direct_drive || (st_reg.tx_from_serial && SERIAL_TX_IN)) |-> tx_request)
    else $error("drive sources not combined");
  a_tx_resume: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (st_reg.tx_locked && !st_reg.oh_s[1] && !tx_request) |=> !st_reg.tx_locked)
    else $error("transmitter not re-enabled");
  a_init_quiet: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (st_reg.txs == TXS_INIT) |-> !BUS_TX_DOMINANT_OUT)
    else $error("tx during init");

  // Wake needs a long dominant level, then a release while in low power
  sequence s_long_dominant;
    st_reg.dom_long && rx_dom;
  endsequence
  sequence s_bus_released;
    !rx_dom && LOW_POWER_IN;
  endsequence
  a_wake_pulse: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    (s_long_dominant ##1 s_bus_released) |=> WAKE_EVENT_OUT) else $error("wake event missed");
  a_wake_kept: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    WAKE_EVENT_OUT |-> st_reg.wake_source_reg[0]) else $error("wake source not recorded");
endmodule : lin_phy_control

// ### core/lin_phy_cfg.svh
`ifndef LIN_PHY_CFG_SVH
`define LIN_PHY_CFG_SVH
// Register word offsets, APB byte addresses are four times the sum of base and these
`define OFS_CTL 8'h50
`define OFS_FAULT 8'h52
`define OFS_LINE 8'h53
`define OFS_TXR 8'h54
`define OFS_RXR 8'h55
`define OFS_SPA 8'h56
`define OFS_SPB 8'h57
`define OFS_WAKE 8'h58
`define OFS_MODE 8'h59
`define BASE_BLOCKING 12'h200
`define BASE_NONBLOCKING 12'h300
// Control field positions
`define CTL_IE_BIT 7
`define CTL_DD_BIT 4
`define CTL_KA_BIT 3
`define CTL_EN_BIT 2
`define CTL_IEM_BIT 15
`define CTL_DDM_BIT 12
`define CTL_KAM_BIT 11
`define CTL_ENM_BIT 10
// Fault flag positions
`define FLT_OT_BIT 7
`define FLT_HF_BIT 5
`define FLT_UV_BIT 3
`define CTL_RESET 16'h0000
// Timing
`define CLK_HZ 10000000
`define READY_TIME_US 50
`define READY_CYCLES ((`READY_TIME_US * `CLK_HZ + 999999) / 1000000)
`define WAKE_DOM_TIME_US 150
`define WAKE_DOM_CYCLES ((`WAKE_DOM_TIME_US * `CLK_HZ + 999999) / 1000000)
`endif

// ### core/lin_phy_pkg.sv
package lin_phy_pkg;
  typedef enum logic [1:0] {
    SLEW_NORMAL = 2'b00,
    SLEW_SLOW = 2'b01,
    SLEW_FAST = 2'b10,
    SLEW_NORMAL_ALT = 2'b11
  } slew_t;
  typedef enum logic [1:0] {
    TXS_OFF = 2'b00,
    TXS_INIT = 2'b01,
    TXS_READY = 2'b10
  } txs_t;
endpackage : lin_phy_pkg

// ### tb/lin_bus_model.sv
`timescale 1ns/1ns
// =====
// Wired bus with pull-up: dominant if any party pulls
module lin_bus_model (
  input wire logic clk_in,
  input wire logic node_dom_in,
  input wire logic master_dom_in,
  input wire logic slow_in,
  output logic bus_dom_out
);
  logic echo_reg;
  always_ff @(posedge clk_in) begin
    echo_reg <= node_dom_in;
  end
  // Slow mode adds one cycle of loop delay
  assign bus_dom_out = master_dom_in | (slow_in ? echo_reg : node_dom_in);
endmodule : lin_bus_model

// ### tb/tb_top.sv
`timescale 1ns/1ns
`include "lin_phy_cfg.svh"
module tb_top;
  import lin_phy_pkg::*;
  typedef struct {logic [15:0] wd; logic [1:0] sl;} row_t;
  localparam int RDY = 10;
  localparam int WK = 20;
  logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, err;
  logic [11:0] paddr = 12'h000, base = `BASE_BLOCKING;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  logic hot = 0, hf = 0, lows = 0, lp = 0, mdom = 0, slow = 0, stx = 0, gtx = 0;
  logic pready, pslverr, tx, srx, grx, irq, wake, rx;
  slew_t slew;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  row_t rows [6] = '{'{16'h0301, 2'h1}, '{16'h0102, 2'h1}, '{16'h0202, 2'h1},
    '{16'h0302, 2'h2}, '{16'h0303, 2'h3}, '{16'h0300, 2'h0}};
  lin_phy_control #(.READY_CYCLES(RDY), .WAKE_CYCLES(WK)) i_lin_phy_control (
    .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .OVERHEAT_IN(hot), .DISTURBANCE_IN(hf), .LOW_SUPPLY_IN(lows),
    .LOW_POWER_IN(lp), .BUS_RX_IN(rx), .SERIAL_TX_IN(stx), .GPIO_TX_IN(gtx),
    .BUS_TX_DOMINANT_OUT(tx), .SERIAL_RX_OUT(srx), .GPIO_RX_OUT(grx),
    .SLEW_OUT(slew), .OVERHEAT_IRQ_OUT(irq), .WAKE_EVENT_OUT(wake));
  lin_bus_model i_lin_bus_model (.clk_in(clk), .node_dom_in(tx),
    .master_dom_in(mdom), .slow_in(slow), .bus_dom_out(rx));
  always #50 clk = ~clk;
  // =====
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic chk1(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask : chk1
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // Read data taken at the access edge, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] off, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= (base + {4'h0, off}) << 2;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
  // =====
  // Main sequence
  initial begin
    wt(6);
    rst_b <= 1'b1;
    apb(0, `OFS_CTL, 32'h0, 4'hF);
    chk(rd, 32'h0);
    apb(0, `OFS_FAULT, 32'h0, 4'hF);
    chk(rd, 32'h0);
    foreach (rows[i]) begin
      apb(1, `OFS_CTL, {16'h0, rows[i].wd}, 4'h3);
      chk({30'h0, slew}, {30'h0, rows[i].sl});
      apb(0, `OFS_CTL, 32'h0, 4'hF);
      chk(rd, 32'h0);
    end
    apb(1, `OFS_CTL, 32'h0301, 4'h1);
    chk({30'h0, slew}, 32'h0);
    slow <= 1'b1;
    apb(1, `OFS_TXR, 32'h1, 4'hF);
    stx <= 1'b1;
    apb(1, `OFS_CTL, 32'h0404, 4'h3);
    wt(2);
    chk1(tx, 0);
    apb(0, `OFS_LINE, 32'h0, 4'hF);
    chk1(rd[7], 0);
    wt(RDY + 4);
    apb(0, `OFS_LINE, 32'h0, 4'hF);
    chk(rd, 32'h83);
    chk1(tx, 1);
    apb(1, `OFS_TXR, 32'h3, 4'hF);
    stx <= 1'b0;
    gtx <= 1'b1;
    wt(4);
    chk1(tx, 0);
    apb(1, `OFS_CTL, 32'h0010, 4'h3);
    wt(2);
    chk1(tx, 0);
    apb(1, `OFS_CTL, 32'h1010, 4'h3);
    wt(2);
    chk1(tx, 1);
    apb(1, `OFS_CTL, 32'h1000, 4'h3);
    apb(1, `OFS_RXR, 32'h1, 4'hF);
    mdom <= 1'b1;
    wt(4);
    chk1(srx, 1);
    chk1(grx, 0);
    apb(1, `OFS_RXR, 32'h2, 4'hF);
    chk1(grx, 1);
    chk1(srx, 0);
    mdom <= 1'b0;
    wt(4);
    chk1(grx, 0);
    apb(1, `OFS_TXR, 32'h1, 4'hF);
    stx <= 1'b1;
    gtx <= 1'b0;
    apb(1, `OFS_CTL, 32'h8080, 4'h3);
    hot <= 1'b1;
    wt(6);
    chk1(tx, 0);
    chk1(irq, 1);
    apb(1, `OFS_FAULT, 32'h80, 4'hF);
    wt(4);
    chk1(irq, 0);
    apb(0, `OFS_MODE, 32'h0, 4'hF);
    chk1(rd[2], 1);
    hot <= 1'b0;
    wt(6);
    chk1(tx, 0);
    stx <= 1'b0;
    wt(4);
    stx <= 1'b1;
    wt(6);
    chk1(tx, 1);
    hot <= 1'b1;
    wt(6);
    chk1(irq, 1);
    apb(1, `OFS_CTL, 32'h0000, 4'h3);
    chk1(irq, 1);
    apb(1, `OFS_CTL, 32'h8000, 4'h3);
    chk1(irq, 0);
    hot <= 1'b0;
    wt(4);
    apb(1, `OFS_FAULT, 32'h80, 4'hF);
    stx <= 1'b0;
    wt(4);
    stx <= 1'b1;
    lows <= 1'b1;
    wt(6);
    chk1(tx, 0);
    apb(0, `OFS_FAULT, 32'h0, 4'hF);
    chk(rd, 32'h08);
    apb(1, `OFS_CTL, 32'h0808, 4'h3);
    wt(4);
    chk1(tx, 1);
    lows <= 1'b0;
    apb(1, `OFS_FAULT, 32'h08, 4'hF);
    hf <= 1'b1;
    wt(4);
    hf <= 1'b0;
    apb(0, `OFS_FAULT, 32'h0, 4'hF);
    chk(rd, 32'h20);
    apb(1, `OFS_FAULT, 32'h20, 4'hF);
    apb(0, `OFS_FAULT, 32'h0, 4'hF);
    chk(rd, 32'h0);
    lp <= 1'b1;
    wt(4);
    chk1(tx, 0);
    mdom <= 1'b1;
    wt(WK + 6);
    mdom <= 1'b0;
    for (int k = 0; k < 10 && wake !== 1'b1; k++) @(posedge clk);
    chk1(wake, 1);
    apb(0, `OFS_WAKE, 32'h0, 4'hF);
    chk1(rd[0], 1);
    lp <= 1'b0;
    base = `BASE_NONBLOCKING;
    apb(0, `OFS_TXR, 32'h0, 4'hF);
    chk(rd, 32'h1);
    chk1(err, 0);
    apb(0, `OFS_SPA, 32'h0, 4'hF);
    chk(rd, 32'h0);
    apb(0, 8'h5A, 32'h0, 4'hF);
    chk1(err, 1);
    apb(1, `OFS_CTL, 32'h0302, 4'h3);
    chk({30'h0, slew}, 32'h2);
    rst_b <= 1'b0;
    wt(2);
    rst_b <= 1'b1;
    wt(1);
    chk({30'h0, slew}, 32'h0);
    chk1(tx, 0);
    test_done();
  end
endmodule : tb_top
